// [hw/sas_adc_seq.sv]
// Control and timing logic of an 8-bit successive-approximation converter with eight inputs.
// Assumes ce marks one machine cycle, and that an external comparator reports input above dac_code.
//
// What this block does
// - Eight-bit successive approximation, one of eight inputs.
// - Sampling phase lasts five machine cycles.
// - Whole conversion takes fifteen machine cycles.
// - Single or continuous conversion mode.
// - End of conversion raises an interrupt request.
// - Capacitor load interval at most two cycles.
// - Analog pins read as digital input port.
`timescale 1ns/1ps

`include "sas_consts.svh"

module sas_adc_seq
  import sas_pkg::*;
(
  // Clock, reset and machine-cycle enable.
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Special function register access.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Analog input pins seen as digital levels.
  input wire logic [7:0] pin_in,
  // Analog front end control.
  output logic [2:0] ain_sel,
  output logic sample_en,
  output logic load_en,
  output logic [7:0] dac_code,
  input wire logic cmp_in,
  output logic [7:0] ref_code,
  // Toward the interrupt logic and status.
  output logic eoc_req,
  output logic busy
);

  sas_state_t st_q;
  logic [3:0] cyc_q;
  logic [2:0] chan_q;
  logic cont_q;
  logic done_q;
  logic [7:0] sar_q;
  logic [7:0] sar_next;
  logic [7:0] result_q;
  logic [7:0] ref_q;
  logic [7:0] rdata_q;
  logic [2:0] sel_q;
  logic eoc_q;
  logic [3:0] bit_pos;
  logic wr_ctrl;
  logic wr_start;
  logic start_now;
  logic finish_now;

  // Register strobes; the port and result addresses take no writes.
  assign wr_ctrl = ce && sfr_wr && (sfr_addr == `SAS_ADDR_CTRL);
  assign wr_start = ce && sfr_wr && (sfr_addr == `SAS_ADDR_START);
  assign start_now = wr_start && (st_q == st_idle);
  assign finish_now = ce && (st_q == st_finish) && (cyc_q == `SAS_CONV_LAST);

  // Address decode answer for the core.
  assign sfr_hit = (sfr_addr == `SAS_ADDR_CTRL) || (sfr_addr == `SAS_ADDR_RESULT) ||
                   (sfr_addr == `SAS_ADDR_START) || (sfr_addr == `SAS_ADDR_PORT);

  // Bit under trial falls from 7 to 0 over the approximation cycles.
  assign bit_pos = `SAS_APPROX_LAST - cyc_q;

  // Phase sequencer; a start write while busy is ignored.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= st_idle;
      cyc_q <= `SAS_CYC_RST;
      sel_q <= `SAS_CHAN_RST;
    end else if (ce) begin
      unique case (st_q)
        st_idle: begin
          if (start_now) begin
            st_q <= st_sample;
            cyc_q <= `SAS_CYC_RST;
            sel_q <= chan_q;
          end
        end
        st_sample: begin
          cyc_q <= cyc_q + `SAS_CYC_STEP;
          if (cyc_q == `SAS_SAMPLE_LAST) begin
            st_q <= st_approx;
          end
        end
        st_approx: begin
          cyc_q <= cyc_q + `SAS_CYC_STEP;
          if (cyc_q == `SAS_APPROX_LAST) begin
            st_q <= st_finish;
          end
        end
        st_finish: begin
          if (cyc_q == `SAS_CONV_LAST) begin
            cyc_q <= `SAS_CYC_RST;
            if (cont_q) begin
              st_q <= st_sample;
              sel_q <= chan_q;
            end else begin
              st_q <= st_idle;
            end
          end else begin
            cyc_q <= cyc_q + `SAS_CYC_STEP;
          end
        end
      endcase
    end
  end

  // Successive-approximation step logic.
  sas_sar_step u_step (
    .code(sar_q),
    .bit_idx(bit_pos[2:0]),
    .cmp_hi(cmp_in),
    .next_code(sar_next)
  );

  // Trial register: seeded at the last sampling cycle, refined once per approximation cycle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sar_q <= `SAS_BYTE_RST;
    end else if (ce) begin
      if ((st_q == st_sample) && (cyc_q == `SAS_SAMPLE_LAST)) begin
        sar_q <= `SAS_SAR_INIT;
      end else if (st_q == st_approx) begin
        sar_q <= sar_next;
      end
    end
  end

  // Result and end-of-conversion request are loaded on the same edge.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_q <= `SAS_BYTE_RST;
      eoc_q <= 1'b0;
    end else if (ce) begin
      eoc_q <= finish_now;
      if (finish_now) begin
        result_q <= sar_q;
      end
    end
  end

  // Control fields; the done flag is cleared by writing zero to it, and a finish in the same cycle wins.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chan_q <= `SAS_CHAN_RST;
      cont_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        chan_q <= sfr_wdata[`SAS_CTRL_CHAN_HI:0];
        cont_q <= sfr_wdata[`SAS_CTRL_CONT];
      end
      if (finish_now) begin
        done_q <= 1'b1;
      end else if (wr_ctrl && !sfr_wdata[`SAS_CTRL_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // Reference setting, stored on every start-register write.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_q <= `SAS_BYTE_RST;
    end else if (wr_start) begin
      ref_q <= sfr_wdata;
    end
  end

  // Read data; the port read only samples the pins and leaves the conversion alone.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= `SAS_BYTE_RST;
    end else if (ce && sfr_rd) begin
      unique case (sfr_addr)
        `SAS_ADDR_CTRL: rdata_q <= {2'h0, done_q, busy, cont_q, chan_q};
        `SAS_ADDR_RESULT: rdata_q <= result_q;
        `SAS_ADDR_START: rdata_q <= ref_q;
        `SAS_ADDR_PORT: rdata_q <= pin_in;
        default: rdata_q <= `SAS_BYTE_RST;
      endcase
    end
  end

  // Front end controls decode from the registered phase and count.
  // The source must hold its level after the load interval; sample_en stays high until the hold ends.
  assign sample_en = (st_q == st_sample);
  assign load_en = (st_q == st_sample) && (cyc_q <= `SAS_LOAD_LAST);
  assign ain_sel = sel_q;
  assign dac_code = sar_q;
  assign ref_code = ref_q;
  assign eoc_req = eoc_q;
  assign busy = (st_q != st_idle);
  assign sfr_rdata = rdata_q;

  // Checks, counted in machine cycles.
  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (!rstn);

  sample_len_a: assert property ($rose(sample_en) |-> sample_en [*5] ##1 !sample_en)
    else $error("Sampling phase is not five cycles.");

  load_len_a: assert property ($rose(load_en) |-> load_en [*2] ##1 !load_en)
    else $error("Load interval is not two cycles.");

  // The request register loads on the fifteenth edge, so it is first seen at the sixteenth tick.
  conv_time_a: assert property (start_now |=> !eoc_req [*8] ##1 !eoc_req [*7] ##1 eoc_req)
    else $error("Conversion did not end after fifteen cycles.");

  result_load_a: assert property (eoc_req |-> (result_q == $past(sar_q)) && done_q)
    else $error("Result or done flag not loaded with the request.");

  single_stop_a: assert property (finish_now && !cont_q |=> !busy && eoc_req && !sample_en)
    else $error("Single mode did not stop.");

  cont_restart_a: assert property (finish_now && cont_q |=> sample_en && load_en && eoc_req)
    else $error("Continuous mode did not restart.");

  chan_hold_a: assert property (busy && $past(busy) && !$rose(sample_en) |-> $stable(ain_sel))
    else $error("Input selection changed within a conversion.");

  port_read_a: assert property (sfr_rd && (sfr_addr == `SAS_ADDR_PORT) |=> sfr_rdata == $past(pin_in))
    else $error("Port read does not show the pins.");

  req_pulse_a: assert property (eoc_req |=> !eoc_req)
    else $error("Request held beyond one cycle.");

  single_cov: cover property (start_now && !cont_q ##16 eoc_req);
  cont_cov: cover property (eoc_req && sample_en ##15 eoc_req);
  port_cov: cover property (busy && sfr_rd && (sfr_addr == `SAS_ADDR_PORT));

endmodule // sas_adc_seq

// [hw/sas_consts.svh]
// Named constants of the converter sequencer: register addresses, fields, reset values and phase timing.
// Assumes one clock-enabled cycle of the core clock is one machine cycle.
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH

// Special function register addresses.
`define SAS_ADDR_CTRL 8'hd8
`define SAS_ADDR_RESULT 8'hd9
`define SAS_ADDR_START 8'hda
`define SAS_ADDR_PORT 8'hdb

// Control register field positions.
`define SAS_CTRL_CHAN_HI 2
`define SAS_CTRL_CONT 3
`define SAS_CTRL_BUSY 4
`define SAS_CTRL_DONE 5

// Reset values.
`define SAS_CHAN_RST 3'h0
`define SAS_BYTE_RST 8'h00
`define SAS_CYC_RST 4'h0

// Phase timing in machine cycles, counted from 0 at the first sampling cycle.
`define SAS_LOAD_LAST 4'h1
`define SAS_SAMPLE_LAST 4'h4
`define SAS_APPROX_LAST 4'hc
`define SAS_CONV_LAST 4'he
`define SAS_CYC_STEP 4'h1

// First trial code of the approximation: only the top bit set.
`define SAS_SAR_INIT 8'h80

`endif

// [hw/sas_pkg.sv]
// Types shared by the converter sequencer files.
// Assumes nothing of its surroundings.
package sas_pkg;

  // Sequencer phases, one-hot.
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_sample = 4'h2,
    st_approx = 4'h4,
    st_finish = 4'h8
  } sas_state_t;

endpackage

// [hw/sas_sar_step.sv]
// One successive-approximation step: decides the bit under trial and sets the next one.
// Assumes the code holds the current trial with the bit under trial already set.
`timescale 1ns/1ps

module sas_sar_step
  import sas_pkg::*;
(
  // Current trial.
  input wire logic [7:0] code,
  input wire logic [2:0] bit_idx,
  input wire logic cmp_hi,
  // Next trial, or the final result after the lowest bit.
  output logic [7:0] next_code
);

  // Clear the trial bit when the input lies below the trial level, then try the bit below.
  always_comb begin
    next_code = code;
    if (!cmp_hi) begin
      next_code[bit_idx] = 1'b0;
    end
    if (bit_idx != 3'h0) begin
      next_code[bit_idx - 3'h1] = 1'b1;
    end
  end

endmodule // sas_sar_step

// [bench/sas_src_model.sv]
// Analog source model: eight channel levels, the sample capacitor and the comparator.
// Assumes the sequencer drives channel, load and trial code on the same clock.
`timescale 1ns/1ps

module sas_src_model
  import sas_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Front end control from the sequencer.
  input wire logic [2:0] ain_sel,
  input wire logic load_en,
  input wire logic [7:0] dac_code,
  // Digital pattern on the pins.
  input wire logic [7:0] pin_pat,
  // Toward the sequencer.
  output logic cmp_in,
  output logic [7:0] pin_in
);
  logic [7:0] held_q;

  // The capacitor charges only during load and then keeps the level constant.
  always @(posedge clk) begin
    if (load_en) begin
      held_q <= 8'h1b + 8'h1d * {5'h00, ain_sel};
    end
  end

  // The comparator reports the held level at or above the trial code.
  assign cmp_in = (held_q >= dac_code);
  assign pin_in = pin_pat;
endmodule // sas_src_model

// [bench/sar_adc_sequencer_bench.sv]
// Self-checking bench of the converter sequencer with the analog source model.
// Assumes ce held high except in the freeze test, so one clock is one machine cycle.
`timescale 1ns/1ps
`include "sas_consts.svh"

module sar_adc_sequencer_bench;
  logic clk, rstn, ce, sfr_wr, sfr_rd, sfr_hit, sample_en, load_en, cmp_in, eoc_req, busy;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pin_in, pin_pat, dac_code, ref_code, rv;
  logic [2:0] ain_sel;
  int failures, checks, cyc, s, l;

  // Design and the analog source facing it.
  sas_adc_seq dut_u (.clk(clk), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .pin_in(pin_in), .ain_sel(ain_sel), .sample_en(sample_en), .load_en(load_en),
    .dac_code(dac_code), .cmp_in(cmp_in), .ref_code(ref_code), .eoc_req(eoc_req), .busy(busy));
  sas_src_model src_u (.clk(clk), .ain_sel(ain_sel), .load_en(load_en), .dac_code(dac_code),
    .pin_pat(pin_pat), .cmp_in(cmp_in), .pin_in(pin_in));

  // Level the source puts on channel k.
  function automatic logic [7:0] lvl(input int k);
    return 8'h1b + 8'h1d * k[7:0];
  endfunction

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares a byte.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Compares a cycle count.
  task automatic chkn(input int got, input int exp, input string msg);
    checks++;
    if (got != exp) begin
      failures++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  // Register write, held until the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
  endtask

  // Register read, data settled after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask

  // Counts cycles, sampling and load cycles up to the end-of-conversion pulse.
  task automatic conv_wait();
    cyc = 0;
    s = 0;
    l = 0;
    do begin
      s += int'(sample_en === 1'b1);
      l += int'(load_en === 1'b1);
      @(posedge clk);
      #1;
      cyc++;
    end while (eoc_req !== 1'b1 && cyc < 40);
    if (eoc_req !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t no end of conversion", $time);
    end
  endtask

  // Registers and outputs after reset.
  task automatic test_reset();
    chk8({6'h00, busy, eoc_req}, 8'h00, "idle outputs");
    chk8(ref_code, 8'h00, "reference reset");
    rd(`SAS_ADDR_CTRL, rv);
    chk8(rv, 8'h00, "control reset");
    rd(`SAS_ADDR_RESULT, rv);
    chk8(rv, 8'h00, "result reset");
  endtask

  // Single conversion on every channel, timing, result and done flag.
  task automatic test_channels();
    for (int k = 0; k < 8; k++) begin
      wr(`SAS_ADDR_CTRL, k[7:0]);
      wr(`SAS_ADDR_START, 8'h40);
      conv_wait();
      chkn(cyc, 15, "conversion cycles");
      chkn(s, 5, "sampling cycles");
      chkn(l, 2, "load cycles");
      chk8({5'h00, ain_sel}, k[7:0], "channel");
      chk8({7'h00, busy}, 8'h00, "single stops");
      @(posedge clk);
      #1;
      chk8({7'h00, eoc_req}, 8'h00, "request pulse");
      rd(`SAS_ADDR_RESULT, rv);
      chk8(rv, lvl(k), "result");
      rd(`SAS_ADDR_CTRL, rv);
      chk8(rv, 8'h20 | k[7:0], "done set");
    end
  endtask

  // A start while busy only changes the reference; the port is read after the conversion ends.
  task automatic test_refuse();
    @(posedge clk);
    pin_pat <= 8'h5a;
    wr(`SAS_ADDR_CTRL, 8'h03);
    rd(`SAS_ADDR_CTRL, rv);
    chk8(rv, 8'h03, "done cleared by write");
    wr(`SAS_ADDR_START, 8'h55);
    wr(`SAS_ADDR_START, 8'h11);
    conv_wait();
    chkn(cyc, 13, "no restart");
    chkn(s, 3, "no second sample");
    rd(`SAS_ADDR_START, rv);
    chk8(rv, 8'h11, "reference");
    chk8(ref_code, 8'h11, "reference output");
    wr(`SAS_ADDR_PORT, 8'hff);
    rd(`SAS_ADDR_PORT, rv);
    chk8(rv, 8'h5a, "port read");
    chk8({7'h00, sfr_hit}, 8'h01, "port mapped");
    rd(`SAS_ADDR_RESULT, rv);
    chk8(rv, lvl(3), "result kept");
    rd(8'hd0, rv);
    chk8(rv, 8'h00, "unmapped read");
    chk8({7'h00, sfr_hit}, 8'h00, "unmapped");
  endtask

  // Continuous mode restarts until the mode bit is cleared.
  task automatic test_cont();
    wr(`SAS_ADDR_CTRL, 8'h0a);
    wr(`SAS_ADDR_START, 8'h00);
    conv_wait();
    conv_wait();
    chkn(cyc, 15, "restart cycles");
    chkn(s, 5, "restart sampling");
    chkn(l, 2, "restart load");
    chk8({5'h00, ain_sel}, 8'h02, "restart channel");
    chk8({7'h00, busy}, 8'h01, "still busy");
    wr(`SAS_ADDR_CTRL, 8'h02);
    conv_wait();
    chkn(cyc, 13, "last conversion cycles");
    chk8({6'h00, busy, eoc_req}, 8'h01, "stops after");
  endtask

  // Holding the enable low freezes a conversion; only enabled cycles count.
  task automatic test_freeze();
    wr(`SAS_ADDR_CTRL, 8'h04);
    wr(`SAS_ADDR_START, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    #1;
    chk8({6'h00, busy, load_en}, 8'h03, "frozen in load");
    conv_wait();
    chkn(cyc, 14, "cycles after freeze");
    rd(`SAS_ADDR_RESULT, rv);
    chk8(rv, lvl(4), "result after freeze");
  endtask

  // Reset in mid-conversion returns to idle, and the next conversion is whole.
  task automatic test_midreset();
    wr(`SAS_ADDR_CTRL, 8'h05);
    wr(`SAS_ADDR_START, 8'h00);
    repeat (3) @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk8({5'h00, busy, eoc_req, sample_en}, 8'h00, "reset mid conversion");
    rd(`SAS_ADDR_CTRL, rv);
    chk8(rv, 8'h00, "control after reset");
    rd(`SAS_ADDR_RESULT, rv);
    chk8(rv, 8'h00, "result after reset");
    wr(`SAS_ADDR_START, 8'h00);
    conv_wait();
    chkn(cyc, 15, "conversion after reset");
    chk8({5'h00, ain_sel}, 8'h00, "channel after reset");
    rd(`SAS_ADDR_RESULT, rv);
    chk8(rv, lvl(0), "result after reset run");
  endtask

  // Clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog against a hang.
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  // Main sequence.
  initial begin
    {rstn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, pin_pat} = '0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    test_reset();
    test_channels();
    test_refuse();
    test_cont();
    test_freeze();
    test_midreset();
    end_sim();
  end
endmodule // sar_adc_sequencer_bench
